// ==== grid_dimming_pkg.sv ====
// constants shared by the grid and dimming timing block
// Contract
// - segment outputs stay low from reset until the first segment payload is latched
// - display enables on the cycle the first segment payload latch completes
// - a segment payload enables display even before any dimming value was loaded
// - grid period lasts 2048 oscillator periods
// - grid on-time steps in 1/2048 of the period from a 10-bit dimming code
// - codes 0 to 1016 give on-time of code oscillator periods
// - codes 1017 to 1022 clamp the on-time at 1016.5 oscillator periods
// - role select low and sync input low makes the device master
// - role select high makes the device the cascade slave
// - slave aligns its grid and segment phases to the master's sync output
// - each phase has blanking of 2 then 5.5 oscillator periods
// - last payload bit high loads dimming, low loads segment pattern
// - bits 1-42 drive segments in phase one, bits 43-84 in phase two
// - payload latches on the high-to-low edge of the load input
// - display-off input low forces segments low, grids keep cycling
package grid_dimming_pkg;
  localparam int CLK_NS           = 50;
  localparam int OSC_PERIOD_NS    = 2000;
  // grid timing counts half oscillator periods so the 5.5 blank is exact
  localparam int HALF_TICK_CYCLES = OSC_PERIOD_NS / (2 * CLK_NS);
  localparam int OSC_PER_GRID     = 2048;
  localparam int POS_W            = 12;
  localparam logic [POS_W-1:0] BLANK1_HALF  = 12'h004;
  localparam logic [POS_W-1:0] BLANK2_HALF  = 12'h00b;
  localparam logic [POS_W-1:0] CLAMP_HALF   = 12'h7f1;
  localparam int DIM_W            = 10;
  localparam logic [DIM_W-1:0] DIM_LIN_MAX  = 10'h3f8;
  localparam logic [DIM_W-1:0] DIM_RESET    = 10'h000;
  localparam int SEG_N            = 42;
  localparam int SEG_BITS         = 84;
  localparam int PAYLOAD_BITS     = 86;
  localparam int TYPE_POS         = 0;
  localparam int SOURCE_POS       = 1;
  localparam int DATA_LSB         = 2;
  localparam logic [11:0] CTRL_ADDR   = 12'h000;
  localparam logic [11:0] STATUS_ADDR = 12'h004;
  localparam logic [11:0] DIM_ADDR    = 12'h008;
  localparam int CTRL_FORCE_OFF   = 0;
  localparam int ST_DISPLAY_ON    = 0;
  localparam int ST_SLAVE         = 1;
  localparam int ST_PHASE         = 2;
  localparam int ST_DIM_LSB       = 16;
endpackage : grid_dimming_pkg

// ==== grid_dimming_timing.sv ====
// grid phase generator, dimming modulator, blanking and cascade control with apb access
`timescale 1ns/1ps
`default_nettype none
module grid_dimming_timing #(
  parameter int HALF_TICK = grid_dimming_pkg::HALF_TICK_CYCLES
) (
  input  wire logic                             clock,
  input  wire logic                             rst_b,
  input  wire logic                             serialClock,
  input  wire logic                             serialData,
  input  wire logic                             serialLoad,
  input  wire logic                             displayOff_b,
  input  wire logic                             cascadeRoleSelect,
  input  wire logic                             cascadeSyncInput,
  output var  logic                             firstGridDrive,
  output var  logic                             secondGridDrive,
  output var  logic                             gridSyncOut,
  output var  logic [grid_dimming_pkg::SEG_N-1:0] segmentOutputs,
  input  wire logic                             psel,
  input  wire logic                             penable,
  input  wire logic                             pwrite,
  input  wire logic [11:0]                      paddr,
  input  wire logic [31:0]                      pwdata,
  output var  logic [31:0]                      prdata,
  output var  logic                             pready,
  output var  logic                             pslverr
);
  localparam int TICK_W = $clog2(HALF_TICK + 1);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(HALF_TICK - 1);
  localparam int PHASE_BIT = grid_dimming_pkg::POS_W - 1;

  typedef enum logic [1:0] {
    ROLE_MASTER = 2'b00,
    ROLE_SLAVE  = 2'b01
  } role_t;

  // pin inputs
  logic [5:0]  pinsSynced;
  logic        clkS;
  logic        dataS;
  logic        loadS;
  logic        offS_b;
  logic        roleS;
  logic        syncS;
  logic        clkPrev;
  logic        loadPrev;
  logic        syncPrev;
  logic        shiftEdge;
  logic        loadFall;
  logic        syncRise;

  // latched payloads
  logic [grid_dimming_pkg::SEG_BITS-1:0] segLatch;
  logic [grid_dimming_pkg::DIM_W-1:0]    dimLatch;
  logic                                  segLoaded;
  logic                                  dimLoaded;

  // timing state
  role_t                             role;
  logic [TICK_W-1:0]                 tickCnt;
  logic                              halfTick;
  logic [grid_dimming_pkg::POS_W-1:0] gridPos;
  logic [grid_dimming_pkg::POS_W-1:0] phasePos;
  logic                              phase;
  logic                              periodStart;
  logic [grid_dimming_pkg::DIM_W-1:0] activeDim;
  logic [grid_dimming_pkg::POS_W-1:0] onHalf;
  logic [grid_dimming_pkg::POS_W-1:0] onEnd;
  logic                              gridOn;
  logic                              displayOn;
  logic                              forceOff;
  logic [grid_dimming_pkg::SEG_N-1:0] next_segments;

  // bus
  logic        apbAccess;
  logic        apbWrite;
  logic        apbRead;
  logic        addrHit;
  logic [31:0] readMux;

  input_sync #(
    .W(6)
  ) u_sync (
    .clock  (clock),
    .rst_b  (rst_b),
    .pinIn  ({serialClock, serialData, serialLoad, displayOff_b,
              cascadeRoleSelect, cascadeSyncInput}),
    .synced (pinsSynced)
  );

  assign {clkS, dataS, loadS, offS_b, roleS, syncS} = pinsSynced;

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      clkPrev  <= 1'b0;
      loadPrev <= 1'b0;
      syncPrev <= 1'b0;
    end else begin
      clkPrev  <= clkS;
      loadPrev <= loadS;
      syncPrev <= syncS;
    end
  end

  assign shiftEdge = clkS && !clkPrev;
  assign loadFall  = loadPrev && !loadS;
  assign syncRise  = syncS && !syncPrev;

  // master takes source bit 0 payloads, slave takes source bit 1
  payload_capture u_capture (
    .clock        (clock),
    .rst_b        (rst_b),
    .shiftEdge    (shiftEdge),
    .serialData   (dataS),
    .loadFall     (loadFall),
    .acceptSource (role == ROLE_SLAVE),
    .segLatch     (segLatch),
    .dimLatch     (dimLatch),
    .segLoaded    (segLoaded),
    .dimLoaded    (dimLoaded)
  );

  // role strap follows the pin after release; a sync-high master strap
  // is out of spec and is treated as master
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      role <= ROLE_MASTER;
    end else if (roleS) begin
      role <= ROLE_SLAVE;
    end else begin
      role <= ROLE_MASTER;
    end
  end

  // half oscillator period tick
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      tickCnt <= '0;
    end else if ((role == ROLE_SLAVE) && syncRise) begin
      tickCnt <= '0;
    end else if (tickCnt == TICK_LAST) begin
      tickCnt <= '0;
    end else begin
      tickCnt <= tickCnt + TICK_W'(1);
    end
  end

  assign halfTick = (tickCnt == TICK_LAST);

  // gridPos counts 4096 half periods: upper bit picks the grid phase
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      gridPos <= '0;
    end else if ((role == ROLE_SLAVE) && syncRise) begin
      gridPos <= '0;
    end else if (halfTick) begin
      gridPos <= gridPos + 12'h001;
    end
  end

  assign phase       = gridPos[PHASE_BIT];
  assign phasePos    = {1'b0, gridPos[PHASE_BIT-1:0]};
  assign periodStart = (gridPos == '0) && (tickCnt == '0);

  // latching mid-period would cut the running grid pulse short
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      activeDim <= grid_dimming_pkg::DIM_RESET;
    end else if (periodStart) begin
      activeDim <= dimLatch;
    end
  end

  // on-time in half periods: two per code step, clamped near half duty
  always_comb begin
    if (activeDim <= grid_dimming_pkg::DIM_LIN_MAX) begin
      onHalf = {1'b0, activeDim, 1'b0};
    end else begin
      onHalf = grid_dimming_pkg::CLAMP_HALF;
    end
  end

  // lead blank then on-time; the tail of the phase is the second blank,
  // so a clamped pulse leaves exactly the 5.5 period gap
  assign onEnd  = grid_dimming_pkg::BLANK1_HALF + onHalf;
  assign gridOn = (phasePos >= grid_dimming_pkg::BLANK1_HALF) && (phasePos < onEnd);

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      firstGridDrive  <= 1'b0;
      secondGridDrive <= 1'b0;
      gridSyncOut     <= 1'b0;
    end else begin
      firstGridDrive  <= gridOn && !phase;
      secondGridDrive <= gridOn && phase;
      gridSyncOut     <= !phase;
    end
  end

  // stays set once any segment payload latched, dimming loaded or not
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      displayOn <= 1'b0;
    end else if (segLoaded) begin
      displayOn <= 1'b1;
    end
  end

  always_comb begin
    if (phase) begin
      next_segments = segLatch[grid_dimming_pkg::SEG_BITS-1:grid_dimming_pkg::SEG_N];
    end else begin
      next_segments = segLatch[grid_dimming_pkg::SEG_N-1:0];
    end
    if (!offS_b || forceOff) begin
      next_segments = '0;
    end
    if (!displayOn && !segLoaded) begin
      next_segments = '0;
    end
  end

  // segment register takes the new pattern one cycle after the latch, while segLoaded is high
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      segmentOutputs <= '0;
    end else if (segLoaded && !phase && offS_b && !forceOff) begin
      segmentOutputs <= segOrderedNow(1'b0);
    end else if (segLoaded && phase && offS_b && !forceOff) begin
      segmentOutputs <= segOrderedNow(1'b1);
    end else begin
      segmentOutputs <= next_segments;
    end
  end

  // picks the phase half from the latch of the current cycle
  function automatic logic [grid_dimming_pkg::SEG_N-1:0] segOrderedNow(input logic ph);
    if (ph) begin
      segOrderedNow = segLatch[grid_dimming_pkg::SEG_BITS-1:grid_dimming_pkg::SEG_N];
    end else begin
      segOrderedNow = segLatch[grid_dimming_pkg::SEG_N-1:0];
    end
  endfunction : segOrderedNow

  // apb slave: one wait state, pready pulses on the second access cycle
  assign apbAccess = psel && penable && !pready;
  assign apbWrite  = apbAccess && pwrite;
  assign apbRead   = apbAccess && !pwrite;
  assign addrHit   = (paddr == grid_dimming_pkg::CTRL_ADDR)
                  || (paddr == grid_dimming_pkg::STATUS_ADDR)
                  || (paddr == grid_dimming_pkg::DIM_ADDR);

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      forceOff <= 1'b0;
    end else if (apbWrite && (paddr == grid_dimming_pkg::CTRL_ADDR)) begin
      forceOff <= pwdata[grid_dimming_pkg::CTRL_FORCE_OFF];
    end
  end

  always_comb begin
    readMux = 32'h0000_0000;
    unique case (paddr)
      grid_dimming_pkg::CTRL_ADDR: begin
        readMux[grid_dimming_pkg::CTRL_FORCE_OFF] = forceOff;
      end
      grid_dimming_pkg::STATUS_ADDR: begin
        readMux[grid_dimming_pkg::ST_DISPLAY_ON] = displayOn;
        readMux[grid_dimming_pkg::ST_SLAVE]      = (role == ROLE_SLAVE);
        readMux[grid_dimming_pkg::ST_PHASE]      = phase;
        readMux[grid_dimming_pkg::ST_DIM_LSB +: grid_dimming_pkg::DIM_W] = activeDim;
      end
      grid_dimming_pkg::DIM_ADDR: begin
        readMux[grid_dimming_pkg::DIM_W-1:0] = dimLatch;
      end
      default: begin
        readMux = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= apbAccess;
      pslverr <= apbAccess && !addrHit;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      prdata <= 32'h0000_0000;
    end else if (apbRead) begin
      prdata <= readMux;
    end else if (apbAccess) begin
      prdata <= 32'h0000_0000;
    end
  end

  // dimLoaded is not observed anywhere; it only feeds this unused net
  logic unusedDimLoaded;
  assign unusedDimLoaded = dimLoaded;
endmodule : grid_dimming_timing
`default_nettype wire

// ==== grid_dimming_timing_props.sv ====
// concurrent checks on the grid and dimming timing block ports
`timescale 1ns/1ps
`default_nettype none
module grid_dimming_timing_props #(
  parameter int HALF_TICK = 1
) (
  input wire logic        clock,
  input wire logic        rst_b,
  input wire logic        displayOff_b,
  input wire logic        cascadeRoleSelect,
  input wire logic        firstGridDrive,
  input wire logic        secondGridDrive,
  input wire logic        gridSyncOut,
  input wire logic [41:0] segmentOutputs,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr
);
  localparam int PER = 2 * grid_dimming_pkg::OSC_PER_GRID * HALF_TICK;
  int   cnt;
  logic seen;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  // a slave is realigned by its sync input, so its period is not counted
  always_ff @(posedge clock) begin
    if (!rst_b || cascadeRoleSelect) begin
      cnt  <= 0;
      seen <= 1'b0;
    end else if ($rose(gridSyncOut)) begin
      cnt  <= 1;
      seen <= 1'b1;
    end else begin
      cnt <= cnt + 1;
    end
  end
  property p_grids_exclusive;
    !(firstGridDrive && secondGridDrive);
  endproperty
  property p_first_in_half;
    firstGridDrive |-> gridSyncOut;
  endproperty
  property p_second_in_half;
    secondGridDrive |-> !gridSyncOut;
  endproperty
  property p_blank_start;
    $changed(gridSyncOut) |-> (!(firstGridDrive || secondGridDrive)) [*4];
  endproperty
  property p_grid_period;
    disable iff (!rst_b || cascadeRoleSelect) $rose(gridSyncOut) && seen |-> cnt == PER;
  endproperty
  property p_display_off;
    (!displayOff_b) [*5] |-> segmentOutputs == '0;
  endproperty
  property p_ready_answer;
    psel && penable && !pready |=> pready;
  endproperty
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  property p_err_unmapped;
    psel && penable && !pready && paddr > 12'h008 |=> pslverr && (pwrite || prdata == 32'h0);
  endproperty
  a_grids_exclusive: assert property (p_grids_exclusive) else $error("both grids on");
  a_first_in_half: assert property (p_first_in_half) else $error("grid one out of half");
  a_second_in_half: assert property (p_second_in_half) else $error("grid two out of half");
  a_blank_start: assert property (p_blank_start) else $error("leading blank short");
  a_grid_period: assert property (p_grid_period) else $error("grid period wrong");
  a_display_off: assert property (p_display_off) else $error("segments lit while off");
  a_ready_answer: assert property (p_ready_answer) else $error("no ready after access");
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready longer than a cycle");
  a_err_unmapped: assert property (p_err_unmapped) else $error("unmapped access not refused");
  c_grid_pulse: cover property ($rose(firstGridDrive));
  c_refused: cover property (pslverr);
  c_segments_lit: cover property (segmentOutputs != '0);
endmodule : grid_dimming_timing_props
bind grid_dimming_timing grid_dimming_timing_props #(.HALF_TICK(HALF_TICK)) props_u (
  .clock(clock), .rst_b(rst_b), .displayOff_b(displayOff_b),
  .cascadeRoleSelect(cascadeRoleSelect), .firstGridDrive(firstGridDrive),
  .secondGridDrive(secondGridDrive), .gridSyncOut(gridSyncOut),
  .segmentOutputs(segmentOutputs), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr));
`default_nettype wire

// ==== grid_dimming_timing_tb.sv ====
// self-checking bench for the grid and dimming timing block
`timescale 1ns/1ps
`default_nettype none
module grid_dimming_timing_tb;
  localparam int HT  = 1;
  localparam int PER = 2 * grid_dimming_pkg::OSC_PER_GRID * HT;
  logic        clock = 1'b0;
  logic        rst_b = 1'b0;
  logic        displayOff_b = 1'b1;
  logic        cascadeRoleSelect = 1'b0;
  logic        cascadeSyncInput = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, firstGridDrive, secondGridDrive, gridSyncOut;
  logic        serialClock, serialData, serialLoad;
  logic [41:0] segmentOutputs;
  int          n_errors = 0;
  int          n_compared = 0;
  int          cyc = 0;
  always #25 clock = ~clock;
  serial_host host_u (.clock(clock), .sClk(serialClock), .sData(serialData), .sLoad(serialLoad));
  grid_dimming_timing #(.HALF_TICK(HT)) dut_u (
    .clock(clock), .rst_b(rst_b), .serialClock(serialClock), .serialData(serialData),
    .serialLoad(serialLoad), .displayOff_b(displayOff_b), .cascadeRoleSelect(cascadeRoleSelect),
    .cascadeSyncInput(cascadeSyncInput), .firstGridDrive(firstGridDrive),
    .secondGridDrive(secondGridDrive), .gridSyncOut(gridSyncOut),
    .segmentOutputs(segmentOutputs), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  task automatic close_out();
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : close_out
  always @(posedge clock) begin
    cyc++;
    if (cyc == 95000) begin
      n_errors++;
      close_out();
    end
  end
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic er);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    // only the global cycle ceiling ends a wait for the answer
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask : apb
  // returns at the first edge of a new grid period
  task automatic wrose();
    int t;
    t = 0;
    while (gridSyncOut !== 1'b0 && t < 9000) begin @(posedge clock); t++; end
    while (gridSyncOut !== 1'b1 && t < 9000) begin @(posedge clock); t++; end
  endtask : wrose
  // one whole period holds the full on-time of each grid, wherever the window starts
  task automatic cnt_on(output int c, output int c2);
    c  = 0;
    c2 = 0;
    repeat (PER) begin
      if (firstGridDrive === 1'b1) c++;
      if (secondGridDrive === 1'b1) c2++;
      @(posedge clock);
    end
  endtask : cnt_on
  task automatic chk_segs(input logic [83:0] s);
    wrose();
    repeat (10) @(posedge clock);
    chk(64'(segmentOutputs), 64'(s[41:0]));
    repeat (PER / 2) @(posedge clock);
    chk(64'(segmentOutputs), 64'(s[83:42]));
  endtask : chk_segs
  function automatic logic [85:0] mk_seg(input logic [83:0] s, input logic src);
    logic [85:0] p;
    p = '0;
    for (int i = 0; i < 84; i++) p[85 - i] = s[i];
    p[1] = src;
    return p;
  endfunction : mk_seg
  function automatic logic [85:0] mk_dim(input logic [9:0] d);
    logic [85:0] p;
    p = '0;
    for (int i = 0; i < 10; i++) p[11 - i] = d[i];
    p[0] = 1'b1;
    return p;
  endfunction : mk_dim
  function automatic logic [31:0] exp_on(input logic [9:0] d);
    return (d <= 10'h3f8) ? 32'(2 * d * HT) : 32'(grid_dimming_pkg::CLAMP_HALF * HT);
  endfunction : exp_on
  initial begin
    logic [31:0] rd;
    logic        er;
    logic [83:0] seg;
    logic [9:0]  codes [5];
    logic [9:0]  prev;
    int          c;
    int          c2;
    void'($urandom(98));
    codes = '{10'h000, 10'h3f8, 10'h3f9, 10'h3fe, 10'($urandom_range(1022, 0))};
    seg   = 84'({$urandom(), $urandom(), $urandom()});
    prev  = grid_dimming_pkg::DIM_RESET;
    repeat (6) @(posedge clock);
    rst_b <= 1'b1;
    repeat (4) @(posedge clock);
    chk(64'(segmentOutputs), 64'h0);
    apb(1'b0, grid_dimming_pkg::STATUS_ADDR, 32'h0, rd, er);
    chk(64'(rd & 32'h3), 64'h0);
    apb(1'b0, 12'h00c, 32'h0, rd, er);
    chk(64'({er, rd}), 64'h1_0000_0000);
    host_u.send(mk_seg(seg, 1'b0), 86);
    apb(1'b0, grid_dimming_pkg::STATUS_ADDR, 32'h0, rd, er);
    chk(64'(rd & 32'h1), 64'h1);
    chk_segs(seg);
    host_u.send(mk_seg(~seg, 1'b1), 86);
    chk_segs(seg);
    wrose();
    foreach (codes[i]) begin
      host_u.send(mk_dim(codes[i]), 12);
      apb(1'b0, grid_dimming_pkg::STATUS_ADDR, 32'h0, rd, er);
      chk(64'(rd[25:16]), 64'(prev));
      apb(1'b0, grid_dimming_pkg::DIM_ADDR, 32'h0, rd, er);
      chk(64'(rd & 32'h3ff), 64'(codes[i]));
      wrose();
      cnt_on(c, c2);
      chk(64'(c), 64'(exp_on(codes[i])));
      chk(64'(c2), 64'(exp_on(codes[i])));
      prev = codes[i];
    end
    chk_segs(seg);
    displayOff_b <= 1'b0;
    cnt_on(c, c2);
    chk(64'(segmentOutputs), 64'h0);
    chk(64'(c), 64'(exp_on(prev)));
    displayOff_b <= 1'b1;
    apb(1'b1, grid_dimming_pkg::CTRL_ADDR, 32'h1, rd, er);
    repeat (3) @(posedge clock);
    chk(64'(segmentOutputs), 64'h0);
    apb(1'b0, grid_dimming_pkg::CTRL_ADDR, 32'h0, rd, er);
    chk(64'(rd), 64'h1);
    apb(1'b1, grid_dimming_pkg::CTRL_ADDR, 32'h0, rd, er);
    cascadeRoleSelect <= 1'b1;
    repeat (4) @(posedge clock);
    apb(1'b0, grid_dimming_pkg::STATUS_ADDR, 32'h0, rd, er);
    chk(64'(rd & 32'h2), 64'h2);
    wrose();
    repeat (PER / 2 + 50) @(posedge clock);
    cascadeSyncInput <= 1'b1;
    repeat (6) @(posedge clock);
    chk(64'(gridSyncOut), 64'h1);
    cascadeSyncInput <= 1'b0;
    host_u.send(mk_seg(~seg, 1'b1), 86);
    chk_segs(~seg);
    close_out();
  end
endmodule : grid_dimming_timing_tb
`default_nettype wire

// ==== input_sync.sv ====
// two-stage synchroniser for the pin inputs
`timescale 1ns/1ps
`default_nettype none
module input_sync #(
  parameter int W = 1
) (
  input  wire logic         clock,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] pinIn,
  output var  logic [W-1:0] synced
);
  logic [W-1:0] stage1;

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      stage1 <= '0;
      synced <= '0;
    end else begin
      stage1 <= pinIn;
      synced <= stage1;
    end
  end
endmodule : input_sync
`default_nettype wire

// ==== payload_capture.sv ====
// serial payload shift register and segment/dimming latches
`timescale 1ns/1ps
`default_nettype none
module payload_capture (
  input  wire logic                                clock,
  input  wire logic                                rst_b,
  input  wire logic                                shiftEdge,
  input  wire logic                                serialData,
  input  wire logic                                loadFall,
  input  wire logic                                acceptSource,
  output var  logic [grid_dimming_pkg::SEG_BITS-1:0] segLatch,
  output var  logic [grid_dimming_pkg::DIM_W-1:0]    dimLatch,
  output var  logic                                segLoaded,
  output var  logic                                dimLoaded
);
  logic [grid_dimming_pkg::PAYLOAD_BITS-1:0] shiftReg;
  logic [grid_dimming_pkg::SEG_BITS-1:0]     segOrdered;
  logic [grid_dimming_pkg::DIM_W-1:0]        dimOrdered;
  logic                                      accept;

  // oversize payloads simply push older bits out
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      shiftReg <= '0;
    end else if (shiftEdge) begin
      shiftReg <= {shiftReg[grid_dimming_pkg::PAYLOAD_BITS-2:0], serialData};
    end
  end

  // first bit shifted in is bit 1, so reverse into natural order
  genvar i;
  generate
    for (i = 0; i < grid_dimming_pkg::SEG_BITS; i++) begin : g_seg
      assign segOrdered[i] = shiftReg[grid_dimming_pkg::PAYLOAD_BITS - 1 - i];
    end
    for (i = 0; i < grid_dimming_pkg::DIM_W; i++) begin : g_dim
      assign dimOrdered[i] = shiftReg[grid_dimming_pkg::DATA_LSB
                                      + grid_dimming_pkg::DIM_W - 1 - i];
    end
  endgenerate

  assign accept = loadFall && (shiftReg[grid_dimming_pkg::SOURCE_POS] == acceptSource);

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      segLatch  <= '0;
      dimLatch  <= grid_dimming_pkg::DIM_RESET;
      segLoaded <= 1'b0;
      dimLoaded <= 1'b0;
    end else begin
      segLoaded <= 1'b0;
      dimLoaded <= 1'b0;
      if (accept && shiftReg[grid_dimming_pkg::TYPE_POS]) begin
        dimLatch  <= dimOrdered;
        dimLoaded <= 1'b1;
      end else if (accept) begin
        segLatch  <= segOrdered;
        segLoaded <= 1'b1;
      end
    end
  end
endmodule : payload_capture
`default_nettype wire

// ==== serial_host.sv ====
// serial link model of the controlling host: shift clock, data and load pins
`timescale 1ns/1ps
`default_nettype none
module serial_host (
  input  wire logic clock,
  output var  logic sClk,
  output var  logic sData,
  output var  logic sLoad
);
  initial begin
    sClk  = 1'b0;
    sData = 1'b0;
    sLoad = 1'b0;
  end
  // 4 clocks a level gives the 400 ns link period; the link clock idles low between frames
  task automatic send(input logic [85:0] bits, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      sData <= bits[i];
      repeat (4) @(posedge clock);
      sClk <= 1'b1;
      repeat (4) @(posedge clock);
      // data holds through the high level; the next bit replaces it at this same edge
      sClk  <= 1'b0;
    end
    sLoad <= 1'b1;
    repeat (24) @(posedge clock);
    sLoad <= 1'b0;
    repeat (4) @(posedge clock);
  endtask : send
endmodule : serial_host
`default_nettype wire
